// ==== rtl/flash_host_consts.vh ====
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
`define CMD_QUERY       16'h0098
`define CMD_RESET       16'h00F0
`define CMD_UNLOCK1     16'h00AA
`define CMD_UNLOCK2     16'h0055
`define CMD_SEC_ENTER   16'h0088
`define CMD_SEC_EXIT    16'h0090
`define CMD_PROGRAM     16'h00A0
`define CMD_EXIT_ZERO   16'h0000
`define ADDR_QUERY_WORD 21'h000055
`define ADDR_QUERY_BYTE 21'h0000AA
`define ADDR_UNLOCK1    21'h000555
`define ADDR_UNLOCK2    21'h0002AA
`define ADDR_ZERO       21'h000000
`define OP_NONE         3'h0
`define OP_READ         3'h1
`define OP_WRITE        3'h2
`define OP_QUERY        3'h3
`define OP_SEC_ENTER    3'h4
`define OP_SEC_EXIT     3'h5
`define OP_RESET        3'h6
`define OP_SEC_PROGRAM  3'h7
`define BUS_PHASE_CYC   4'h8
`endif

// ==== rtl/flash_bus_cycle.v ====
`timescale 1ns/10ps
`include "flash_host_consts.vh"
// One asynchronous bus cycle: address, strobe low, strobe high
module flash_bus_cycle
(
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        start_i,
  input  wire        write_i,
  output reg         done_o,
  output reg         busy_o,
  output reg         ce_n_o,
  output reg         we_n_o,
  output reg         oe_n_o,
  output reg         dq_oe_n_o,
  output reg  [1:0]  phase_o
);
  reg [3:0] cnt_r;
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_r     <= 4'h0;
      phase_o   <= 2'h0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      ce_n_o    <= 1'b1;
      we_n_o    <= 1'b1;
      oe_n_o    <= 1'b1;
      dq_oe_n_o <= 1'b1;
    end
    else
    begin
      done_o <= 1'b0;
      if (!busy_o)
      begin
        if (start_i)
        begin
          busy_o    <= 1'b1;
          phase_o   <= 2'h1;
          cnt_r     <= `BUS_PHASE_CYC;
          dq_oe_n_o <= !write_i;
          oe_n_o    <= 1'b1;
        end
      end
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      else
      begin
        case (phase_o)
          2'h1:
          begin
            // Write needs CE and WE low with OE high
            ce_n_o  <= 1'b0;
            we_n_o  <= !write_i ? 1'b1 : 1'b0;
            oe_n_o  <= write_i;
            phase_o <= 2'h2;
            cnt_r   <= `BUS_PHASE_CYC;
          end
          2'h2:
          begin
            // Data latched on the first rising strobe
            ce_n_o  <= 1'b1;
            we_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            phase_o <= 2'h3;
            cnt_r   <= `BUS_PHASE_CYC;
          end
          default:
          begin
            dq_oe_n_o <= 1'b1;
            busy_o    <= 1'b0;
            done_o    <= 1'b1;
            phase_o   <= 2'h0;
          end
        endcase
      end
    end
  end
endmodule

// ==== rtl/flash_host_ctrl.v ====
// Notes on behaviour
// - Unprotect request holds reset pin at high program voltage.
// - Enter sequence maps secure sector until exit or power off.
// - Secure programming uses the normal program sequence only.
// - Lock uses enter sequence; reset pin high or high voltage.
// - Host writes exit sequence before touching the array again.
// - Write only with chip and write enable low, output high.
// - Query command 98h at 55h word or AAh byte enters query.
// - Reset command leaves query; no query during embedded op.
// - Address on later falling strobe, data on earlier rising.
`timescale 1ns/10ps
`include "flash_host_consts.vh"
module flash_host_ctrl
#(
  parameter AW = 21,
  parameter DW = 16
)
(
  input  wire          CLK_SYS_I,
  input  wire          RESETN_I,
  input  wire          REQ_I,
  input  wire [2:0]    OP_I,
  input  wire [AW-1:0] ADDR_I,
  input  wire [DW-1:0] WDATA_I,
  input  wire          BYTE_MODE_I,
  input  wire          UNPROTECT_I,
  input  wire          WP_KEEP_I,
  input  wire          EMBEDDED_BUSY_I,
  input  wire          SUPPLY_OK_I,
  input  wire [DW-1:0] DQ_I,
  output reg           BUSY_O,
  output reg           DONE_O,
  output reg  [DW-1:0] RDATA_O,
  output reg           REFUSED_O,
  output reg           SECURE_MODE_O,
  output reg           QUERY_MODE_O,
  output reg  [AW-1:0] ADDR_O,
  output reg  [DW-1:0] DQ_O,
  output reg           DQ_OE_N_O,
  output reg           CE_N_O,
  output reg           WE_N_O,
  output reg           OE_N_O,
  output reg           RESET_N_O,
  output reg           HIGH_PROGRAM_VOLTAGE_O,
  output reg           WRITE_PROTECT_ACCEL_PIN_O
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEQ  = 2'h1;
  localparam ST_WAIT = 2'h2;
  reg  [1:0]    state_r;
  reg  [2:0]    op_r;
  reg  [2:0]    step_r;
  reg  [AW-1:0] addr_r;
  reg  [DW-1:0] wdata_r;
  reg  [DW-1:0] dq_m_r;
  reg  [DW-1:0] dq_r;
  reg           byte_r;
  reg           start_r;
  reg           write_r;
  reg           ok_m_r, ok_r, busy_m_r, busy_r, unp_m_r, unp_r, wp_m_r, wp_r;
  reg  [AW-1:0] cyc_addr;
  reg  [DW-1:0] cyc_data;
  reg           cyc_write;
  reg  [2:0]    cyc_last;
  wire          cyc_done;
  wire          cyc_busy;
  wire          ce_n, we_n, oe_n, dq_oe_n;
  wire [1:0]    phase;

  flash_bus_cycle u_cycle
  (
    .clk_i     (CLK_SYS_I),
    .resetn_i  (RESETN_I),
    .start_i   (start_r),
    .write_i   (write_r),
    .done_o    (cyc_done),
    .busy_o    (cyc_busy),
    .ce_n_o    (ce_n),
    .we_n_o    (we_n),
    .oe_n_o    (oe_n),
    .dq_oe_n_o (dq_oe_n),
    .phase_o   (phase)
  );

  // Bus cycle table per operation and step
  always @*
  begin
    cyc_addr  = addr_r;
    cyc_data  = wdata_r;
    cyc_write = 1'b1;
    cyc_last  = 3'h0;
    case (op_r)
      `OP_READ:
        cyc_write = 1'b0;
      `OP_QUERY:
      begin
        // Query address depends on bus width
        cyc_addr = byte_r ? `ADDR_QUERY_BYTE : `ADDR_QUERY_WORD;
        cyc_data = `CMD_QUERY;
      end
      `OP_RESET:
        cyc_data = `CMD_RESET;
      `OP_SEC_ENTER, `OP_SEC_EXIT, `OP_SEC_PROGRAM:
      begin
        // Three-cycle unlocked sequence, four for exit and program, normal program only
        // Secure area lock is one-time on the device
        cyc_last = (op_r == `OP_SEC_EXIT) ? 3'h3 :
                   (op_r == `OP_SEC_PROGRAM) ? 3'h3 : 3'h2;
        case (step_r)
          3'h0:
          begin
            cyc_addr = `ADDR_UNLOCK1;
            cyc_data = `CMD_UNLOCK1;
          end
          3'h1:
          begin
            cyc_addr = `ADDR_UNLOCK2;
            cyc_data = `CMD_UNLOCK2;
          end
          3'h2:
          begin
            cyc_addr = `ADDR_UNLOCK1;
            cyc_data = (op_r == `OP_SEC_ENTER) ? `CMD_SEC_ENTER :
                       (op_r == `OP_SEC_EXIT) ? `CMD_SEC_EXIT :
                       `CMD_PROGRAM;
          end
          default:
          begin
            if (op_r == `OP_SEC_EXIT)
            begin
              cyc_addr = `ADDR_ZERO;
              cyc_data = `CMD_EXIT_ZERO;
            end
          end
        endcase
      end
      default:
        cyc_write = 1'b1;
    endcase
  end

  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      {ok_m_r, ok_r, busy_m_r, busy_r} <= 4'h0;
      {unp_m_r, unp_r, wp_m_r, wp_r}   <= 4'h0;
      state_r  <= ST_IDLE;
      op_r     <= `OP_NONE;
      step_r   <= 3'h0;
      addr_r   <= {AW{1'b0}};
      wdata_r  <= {DW{1'b0}};
      dq_m_r   <= {DW{1'b0}};
      dq_r     <= {DW{1'b0}};
      byte_r   <= 1'b0;
      start_r  <= 1'b0;
      write_r  <= 1'b0;
      BUSY_O   <= 1'b0;
      DONE_O   <= 1'b0;
      RDATA_O  <= {DW{1'b0}};
      REFUSED_O <= 1'b0;
      SECURE_MODE_O <= 1'b0;
      QUERY_MODE_O  <= 1'b0;
      ADDR_O   <= {AW{1'b0}};
      DQ_O     <= {DW{1'b0}};
      DQ_OE_N_O <= 1'b1;
      CE_N_O   <= 1'b1;
      WE_N_O   <= 1'b1;
      OE_N_O   <= 1'b1;
      RESET_N_O <= 1'b0;
      HIGH_PROGRAM_VOLTAGE_O <= 1'b0;
      WRITE_PROTECT_ACCEL_PIN_O <= 1'b0;
    end
    else
    begin
      ok_m_r <= SUPPLY_OK_I;
      ok_r   <= ok_m_r;
      busy_m_r <= EMBEDDED_BUSY_I;
      busy_r   <= busy_m_r;
      unp_m_r <= UNPROTECT_I;
      unp_r   <= unp_m_r;
      wp_m_r  <= WP_KEEP_I;
      wp_r    <= wp_m_r;
      // Data pins pass two flops like the other pins
      dq_m_r  <= DQ_I;
      dq_r    <= dq_m_r;
      // Hold device in reset until supply is good
      RESET_N_O <= ok_r;
      // Unprotect by high voltage on reset pin
      HIGH_PROGRAM_VOLTAGE_O <= ok_r & unp_r;
      // Pin low keeps outer boot sectors locked
      WRITE_PROTECT_ACCEL_PIN_O <= ~wp_r;
      DONE_O    <= 1'b0;
      REFUSED_O <= 1'b0;
      start_r   <= 1'b0;
      CE_N_O    <= ce_n;
      WE_N_O    <= we_n;
      OE_N_O    <= oe_n;
      DQ_OE_N_O <= dq_oe_n;
      case (state_r)
        ST_IDLE:
        begin
          if (REQ_I)
          begin
            // Refuse when supply low, no op, or query during embedded op
            if (!ok_r || OP_I == `OP_NONE ||
                (OP_I == `OP_QUERY && busy_r))
              REFUSED_O <= 1'b1;
            else
            begin
              op_r    <= OP_I;
              addr_r  <= ADDR_I;
              wdata_r <= WDATA_I;
              byte_r  <= BYTE_MODE_I;
              step_r  <= 3'h0;
              BUSY_O  <= 1'b1;
              state_r <= ST_SEQ;
            end
          end
        end
        ST_SEQ:
        begin
          // Address stable before both strobes fall
          if (!cyc_busy)
          begin
            ADDR_O  <= cyc_addr;
            DQ_O    <= cyc_data;
            write_r <= cyc_write;
            start_r <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // Read data taken while output enable is low
          if (op_r == `OP_READ && phase == 2'h2)
            RDATA_O <= dq_r;
          if (cyc_done)
          begin
            if (step_r == cyc_last)
            begin
              state_r <= ST_IDLE;
              BUSY_O  <= 1'b0;
              DONE_O  <= 1'b1;
              if (op_r == `OP_QUERY)
                QUERY_MODE_O <= 1'b1;
              if (op_r == `OP_RESET)
                QUERY_MODE_O <= 1'b0;
              if (op_r == `OP_SEC_ENTER)
                SECURE_MODE_O <= 1'b1;
              if (op_r == `OP_SEC_EXIT)
                SECURE_MODE_O <= 1'b0;
            end
            else
            begin
              step_r  <= step_r + 3'h1;
              state_r <= ST_SEQ;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
      // Supply loss drops modes, even at op end
      if (!ok_r)
      begin
        SECURE_MODE_O <= 1'b0;
        QUERY_MODE_O  <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/flash_host_ctrl_checker.sv ====
`timescale 1ns/10ps
module flash_host_ctrl_checker
(
  input wire        CLK_SYS_I,
  input wire        RESETN_I,
  input wire        BUSY_O,
  input wire        WP_KEEP_I,
  input wire [20:0] ADDR_O,
  input wire [15:0] DQ_O,
  input wire        DQ_OE_N_O,
  input wire        CE_N_O,
  input wire        WE_N_O,
  input wire        OE_N_O,
  input wire        RESET_N_O,
  input wire        SECURE_MODE_O,
  input wire        QUERY_MODE_O,
  input wire        HIGH_PROGRAM_VOLTAGE_O,
  input wire        WRITE_PROTECT_ACCEL_PIN_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  chk_we_qual: assert property (!WE_N_O |-> OE_N_O && !CE_N_O)
    else $error("write strobe unqualified");
  chk_we_drive: assert property (!WE_N_O |-> !DQ_OE_N_O)
    else $error("write without data");
  chk_rd_float: assert property (!OE_N_O |-> DQ_OE_N_O)
    else $error("host drives during read");
  chk_data_held: assert property (!WE_N_O [*2] |-> $stable({ADDR_O, DQ_O}))
    else $error("address or data moved in strobe");
  chk_hv_supply: assert property (HIGH_PROGRAM_VOLTAGE_O |-> RESET_N_O)
    else $error("high voltage without supply");
  chk_idle_pins: assert property (!BUSY_O |-> CE_N_O && WE_N_O)
    else $error("strobe while idle");
  chk_sec_reset: assert property (!RESET_N_O [*3] |-> !SECURE_MODE_O)
    else $error("secure mode kept over reset");
  chk_wp_follow: assert property (WP_KEEP_I [*4] |-> !WRITE_PROTECT_ACCEL_PIN_O)
    else $error("protect pin not low");
  cover property ($rose(QUERY_MODE_O));
  cover property ($rose(SECURE_MODE_O));
  cover property ($rose(HIGH_PROGRAM_VOLTAGE_O));
endmodule
bind flash_host_ctrl flash_host_ctrl_checker u_chk (.*);

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/10ps
module flash_dev_model
#(
  parameter LOCKED = 1
)
(
  input  wire [20:0] a_i,
  input  wire [15:0] d_i,
  input  wire        ce_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire        rst_n_i,
  output wire [15:0] q_o
);
  reg  [20:0] la_r;
  reg  [1:0]  md_r;
  reg  [2:0]  sq_r;
  reg  [15:0] lst_r;
  reg  [15:0] rd;
  reg  [15:0] sec_r [0:15];
  integer     k;
  wire [15:0] dd;
  wire        wr_n = ce_n_i | we_n_i | ~oe_n_i;
  wire [20:0] qa = a_i > 21'h1F ? a_i >> 1 : a_i;
  assign #1 dd = d_i;
  assign q_o = ce_n_i | oe_n_i ? ~lst_r : rd;
  initial
  begin
    lst_r = 16'h0;
    for (k = 0; k < 16; k = k + 1)
      sec_r[k] = 16'hA500 + k;
  end
  always @(posedge oe_n_i)
    lst_r <= rd;
  always @*
    if (md_r == 2'h1)
      rd = qa == 21'h10 ? 16'h51 : qa == 21'h11 ? 16'h52 : qa == 21'h12 ?
        16'h59 : qa == 21'h13 ? 16'h2 : qa == 21'h15 ? 16'h40 : 16'h0;
    else if (md_r == 2'h2 && a_i < 21'h10)
      rd = sec_r[a_i[3:0]];
    else
      rd = ~a_i[15:0];
  always @(negedge wr_n)
    la_r <= a_i;
  always @(posedge wr_n or negedge rst_n_i)
    if (!rst_n_i)
    begin
      md_r <= 2'h0;
      sq_r <= 3'h0;
    end
    else
    begin
      sq_r <= dd == 16'hAA && la_r == 21'h555 ? 3'h1 :
        sq_r == 3'h1 && dd == 16'h55 ? 3'h2 :
        sq_r == 3'h2 && dd == 16'h90 ? 3'h3 :
        sq_r == 3'h2 && dd == 16'hA0 ? 3'h4 : 3'h0;
      if (sq_r == 3'h2 && dd == 16'h88)
        md_r <= 2'h2;
      if ((sq_r == 3'h3 && dd == 16'h0) || dd == 16'hF0)
        md_r <= 2'h0;
      if (dd == 16'h98 && (la_r == 21'h55 || la_r == 21'hAA))
        md_r <= 2'h1;
      if (sq_r == 3'h4 && md_r == 2'h2 && LOCKED == 0)
        sec_r[la_r[3:0]] <= dd;
    end
endmodule

// ==== tb/flash_host_ctrl_tb.sv ====
`timescale 1ns/10ps
module flash_host_ctrl_tb;
  reg         CLK_SYS_I, RESETN_I, REQ_I, BYTE_MODE_I, UNPROTECT_I;
  reg         WP_KEEP_I, EMBEDDED_BUSY_I, SUPPLY_OK_I;
  reg  [2:0]  OP_I;
  reg  [20:0] ADDR_I;
  reg  [15:0] WDATA_I;
  wire [15:0] DQ_I, RDATA_O, DQ_O;
  wire [20:0] ADDR_O;
  wire        BUSY_O, DONE_O, REFUSED_O, SECURE_MODE_O, QUERY_MODE_O;
  wire        DQ_OE_N_O, CE_N_O, WE_N_O, OE_N_O, RESET_N_O;
  wire        HIGH_PROGRAM_VOLTAGE_O, WRITE_PROTECT_ACCEL_PIN_O;
  reg  [1:0]  got;
  integer     n_checks, n_mismatch;
  flash_host_ctrl dut (.*);
  flash_dev_model fm (.a_i(ADDR_O), .d_i(DQ_O), .ce_n_i(CE_N_O),
    .we_n_i(WE_N_O), .oe_n_i(OE_N_O), .rst_n_i(RESET_N_O), .q_o(DQ_I));
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wt;
    repeat (8) @(negedge CLK_SYS_I);
  endtask
  task op(input [2:0] o, input [20:0] a);
    integer k;
    begin
      @(negedge CLK_SYS_I);
      {OP_I, ADDR_I, REQ_I, got} = {o, a, 3'h4};
      for (k = 0; k < 400 && got == 2'h0; k = k + 1)
      begin
        @(negedge CLK_SYS_I);
        if (BUSY_O === 1'h1)
          REQ_I = 1'h0;
        got = {DONE_O === 1'h1, REFUSED_O === 1'h1};
      end
      REQ_I = 1'h0;
      if (got == 2'h0)
      begin
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
      end
    end
  endtask
  function [15:0] qv(input integer i);
    qv = i == 0 ? 16'h51 : i == 1 ? 16'h52 : i == 2 ? 16'h59 :
      i == 3 ? 16'h2 : i == 5 ? 16'h40 : 16'h0;
  endfunction
  task t_query;
    integer i;
    begin
      op(3'h3, 21'h0);
      chk("qmode", QUERY_MODE_O, 16'h1);
      for (i = 0; i < 11; i = i + 1)
      begin
        op(3'h1, 21'h10 + i[20:0]);
        chk("qry", RDATA_O, qv(i));
      end
      op(3'h6, 21'h0);
      chk("qexit", QUERY_MODE_O, 16'h0);
      op(3'h1, 21'h10);
      chk("array", RDATA_O, 16'hFFEF);
      BYTE_MODE_I = 1'h1;
      op(3'h3, 21'h0);
      op(3'h1, 21'h24);
      chk("qbyte", RDATA_O, 16'h59);
      WDATA_I = 16'h00F0;
      op(3'h2, 21'h0);
      op(3'h1, 21'h24);
      chk("rawrst", RDATA_O, 16'hFFDB);
      op(3'h6, 21'h0);
      BYTE_MODE_I = 1'h0;
    end
  endtask
  task t_busy;
    begin
      EMBEDDED_BUSY_I = 1'h1;
      wt;
      op(3'h3, 21'h0);
      chk("qbusy", got, 16'h1);
      {EMBEDDED_BUSY_I, SUPPLY_OK_I} = 2'h0;
      wt;
      op(3'h1, 21'h0);
      chk("lowvcc", got, 16'h1);
      SUPPLY_OK_I = 1'h1;
      wt;
    end
  endtask
  task t_secure;
    begin
      op(3'h4, 21'h0);
      chk("secin", SECURE_MODE_O, 16'h1);
      WDATA_I = 16'h1234;
      op(3'h7, 21'h3);
      op(3'h1, 21'h3);
      chk("secrd", RDATA_O, 16'hA503);
      op(3'h5, 21'h0);
      op(3'h1, 21'h3);
      chk("secout", RDATA_O, 16'hFFFC);
      op(3'h4, 21'h0);
      SUPPLY_OK_I = 1'h0;
      wt;
      chk("secrst", SECURE_MODE_O, 16'h0);
      SUPPLY_OK_I = 1'h1;
      wt;
      op(3'h1, 21'hB);
      chk("arr0", RDATA_O, 16'hFFF4);
    end
  endtask
  task t_pins;
    begin
      {UNPROTECT_I, WP_KEEP_I} = 2'h3;
      wt;
      chk("hv", HIGH_PROGRAM_VOLTAGE_O, 16'h1);
      chk("wp", WRITE_PROTECT_ACCEL_PIN_O, 16'h0);
      {UNPROTECT_I, WP_KEEP_I} = 2'h0;
      wt;
      chk("hvoff", HIGH_PROGRAM_VOLTAGE_O, 16'h0);
      chk("wpoff", WRITE_PROTECT_ACCEL_PIN_O, 16'h1);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    CLK_SYS_I = 1'h0;
    forever #4 CLK_SYS_I = ~CLK_SYS_I;
  end
  initial
  begin
    #400000 n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial
  begin
    {RESETN_I, REQ_I, BYTE_MODE_I, UNPROTECT_I, WP_KEEP_I} = 5'h0;
    {EMBEDDED_BUSY_I, OP_I, ADDR_I, WDATA_I, got} = 43'h0;
    SUPPLY_OK_I = 1'h1;
    n_checks = 0;
    n_mismatch = 0;
    repeat (6) @(negedge CLK_SYS_I);
    RESETN_I = 1'h1;
    wt;
    t_query;
    t_busy;
    t_secure;
    t_pins;
    tally_and_finish;
  end
endmodule
